//--- umic_pkg.sv
// constants, types and encodings shared by the instruction core
package umic_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W = 14;
	localparam int RAM_DEPTH = 256;
	localparam logic [13:0] PC_RESET = 14'h0000;
	localparam logic [7:0] PSTK_RESET = 8'h00;
	localparam logic [7:0] DSTK_RESET = 8'h00;
	localparam logic [13:0] TEST_AREA_BASE = 14'h1fe0;
	localparam logic [1:0] CALL5_HI = 2'h1;
	localparam logic [1:0] CALL9_HI = 2'h0;
	localparam int STK_C_BIT = 7;
	localparam int STK_Z_BIT = 6;
	// instruction lengths in cpu cycles
	localparam logic [3:0] CYC4 = 4'h4;
	localparam logic [3:0] CYC5 = 4'h5;
	localparam logic [3:0] CYC6 = 4'h6;
	localparam logic [3:0] CYC7 = 4'h7;
	localparam logic [3:0] CYC8 = 4'h8;
	localparam logic [3:0] CYC10 = 4'ha;
	localparam logic [3:0] CYC14 = 4'he;
	localparam logic [3:0] CYC_INTACK = 4'ha;
	// opcodes
	localparam logic [7:0] OP_HALT = 8'h00;
	localparam logic [7:0] OP_ALU_FIRST = 8'h01;
	localparam logic [7:0] OP_ALU_LAST = 8'h1b;
	localparam logic [7:0] OP_MOVX_IMM = 8'h1c;
	localparam logic [7:0] OP_MOVX_DIR = 8'h1d;
	localparam logic [7:0] OP_RESERVED = 8'h1e;
	localparam logic [7:0] OP_PAGE_ADVANCE = 8'h1f;
	localparam logic [7:0] OP_NOP = 8'h20;
	localparam logic [7:0] OP_INC_A = 8'h21;
	localparam logic [7:0] OP_INC_X = 8'h22;
	localparam logic [7:0] OP_INC_DIR = 8'h23;
	localparam logic [7:0] OP_INC_IDX = 8'h24;
	localparam logic [7:0] OP_DEC_A = 8'h25;
	localparam logic [7:0] OP_DEC_X = 8'h26;
	localparam logic [7:0] OP_DEC_DIR = 8'h27;
	localparam logic [7:0] OP_DEC_IDX = 8'h28;
	localparam logic [7:0] OP_PORT_READ = 8'h29;
	localparam logic [7:0] OP_PORT_WRITE = 8'h2a;
	localparam logic [7:0] OP_POP_A = 8'h2b;
	localparam logic [7:0] OP_POP_X = 8'h2c;
	localparam logic [7:0] OP_PUSH_A = 8'h2d;
	localparam logic [7:0] OP_PUSH_X = 8'h2e;
	localparam logic [7:0] OP_SWAP_AX = 8'h2f;
	localparam logic [7:0] OP_SWAP_ADSTK = 8'h30;
	localparam logic [7:0] OP_STORE_DIR = 8'h31;
	localparam logic [7:0] OP_STORE_IDX = 8'h32;
	localparam logic [7:0] OP_OR_DIR = 8'h33;
	localparam logic [7:0] OP_OR_IDX = 8'h34;
	localparam logic [7:0] OP_AND_DIR = 8'h35;
	localparam logic [7:0] OP_AND_IDX = 8'h36;
	localparam logic [7:0] OP_XOR_DIR = 8'h37;
	localparam logic [7:0] OP_XOR_IDX = 8'h38;
	localparam logic [7:0] OP_PORT_WRITE_IDX = 8'h39;
	localparam logic [7:0] OP_COMPLEMENT = 8'h3a;
	localparam logic [7:0] OP_SHIFT_LEFT = 8'h3b;
	localparam logic [7:0] OP_SHIFT_RIGHT = 8'h3c;
	localparam logic [7:0] OP_ROT_LEFT = 8'h3d;
	localparam logic [7:0] OP_ROT_RIGHT = 8'h3e;
	localparam logic [7:0] OP_RETURN = 8'h3f;
	localparam logic [7:0] OP_MOV_AX = 8'h40;
	localparam logic [7:0] OP_MOV_XA = 8'h41;
	localparam logic [7:0] OP_LOAD_PSTK = 8'h60;
	localparam logic [7:0] OP_INT_DISABLE = 8'h70;
	localparam logic [7:0] OP_INT_ENABLE = 8'h72;
	localparam logic [7:0] OP_RETURN_INT = 8'h73;
	// upper nibbles of branch forms
	localparam logic [3:0] NIB_CALL5 = 4'h5;
	localparam logic [3:0] NIB_JUMP = 4'h8;
	localparam logic [3:0] NIB_CALL9 = 4'h9;
	localparam logic [3:0] NIB_JUMP_IF_ZERO = 4'ha;
	localparam logic [3:0] NIB_JUMP_IF_NONZERO = 4'hb;
	localparam logic [3:0] NIB_JUMP_IF_CARRY = 4'hc;
	localparam logic [3:0] NIB_JUMP_IF_NO_CARRY = 4'hd;
	localparam logic [3:0] NIB_JUMP_ACC = 4'he;
	localparam logic [3:0] NIB_TABLE = 4'hf;
	// alu groups, in opcode order
	localparam logic [3:0] ALU_ADD = 4'h0;
	localparam logic [3:0] ALU_ADD_CARRY = 4'h1;
	localparam logic [3:0] ALU_SUB = 4'h2;
	localparam logic [3:0] ALU_SUB_BORROW = 4'h3;
	localparam logic [3:0] ALU_OR = 4'h4;
	localparam logic [3:0] ALU_AND = 4'h5;
	localparam logic [3:0] ALU_XOR = 4'h6;
	localparam logic [3:0] ALU_CMP = 4'h7;
	localparam logic [3:0] ALU_MOV = 4'h8;
	localparam logic [7:0] ALU_MODES = 8'h03;

	typedef enum logic [1:0] {AM_NONE, AM_IMM, AM_DIR, AM_IDX} umic_amode_t;
	typedef enum logic [2:0] {
		ST_FETCH = 3'b000,
		ST_OPND = 3'b001,
		ST_EXEC = 3'b011,
		ST_WAIT = 3'b010,
		ST_TABLE = 3'b110,
		ST_HALT = 3'b111
	} umic_state_t;
	typedef struct packed {
		logic two_byte;
		umic_amode_t amode;
		logic [3:0] cyc;
	} umic_dec_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} umic_io_t;
endpackage

//--- umic_core.sv
// instruction decode, programming model and data ram of the 8-bit core
`timescale 1ns/1ns
module umic_core
	import umic_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	output logic [13:0] prog_addr,
	input wire logic [7:0] prog_rdata,
	output umic_pkg::umic_io_t io_req,
	input wire logic [7:0] io_rdata,
	input wire logic irq_req,
	input wire logic [3:0] irq_vector,
	output logic irq_ack,
	output logic irq_enabled,
	output logic halted,
	output logic test_area_hit
);
	import umic_pkg::*;

	umic_state_t state_ff, nxt_state;
	logic [13:0] pc_ff, nxt_pc;
	logic [7:0] a_ff, nxt_a, x_ff, nxt_x, op_ff, nxt_op, opd_ff, nxt_opd;
	logic [7:0] program_stack_pointer_ff, nxt_program_stack_pointer;
	logic [7:0] data_stack_ptr_ff, nxt_data_stack_ptr;
	logic c_ff, nxt_c, z_ff, nxt_z, ie_ff, nxt_ie;
	logic [3:0] cnt_ff, nxt_cnt, cyc_ff, nxt_cyc;
	logic ack_ff, nxt_ack, hit_ff, nxt_hit;
	umic_io_t io_ff, nxt_io;
	logic [7:0] mem_ff [RAM_DEPTH];
	logic we0, we1;
	logic [7:0] wa0, wa1, wd0, wd1;

	function automatic umic_dec_t decode(input logic [7:0] op);
		umic_dec_t d;
		logic [7:0] idx;
		d = '{two_byte: 1'b0, amode: AM_NONE, cyc: CYC4};
		idx = op - OP_ALU_FIRST;
		if (op >= OP_ALU_FIRST && op <= OP_ALU_LAST)
		begin
			d.two_byte = 1'b1;
			unique case (2'(idx % ALU_MODES))
				2'h0: d.amode = AM_IMM;
				2'h1: d.amode = AM_DIR;
				default: d.amode = AM_IDX;
			endcase
			unique case (4'(idx / ALU_MODES))
				ALU_CMP: d.cyc = (d.amode == AM_IMM) ? CYC5 : (d.amode == AM_DIR) ? CYC7 : CYC8;
				ALU_MOV: d.cyc = (d.amode == AM_IMM) ? CYC4 : (d.amode == AM_DIR) ? CYC5 : CYC6;
				default: d.cyc = (d.amode == AM_IMM) ? CYC4 : (d.amode == AM_DIR) ? CYC6 : CYC7;
			endcase
		end
		else if (op[7:4] == NIB_CALL5 || op[7] == 1'b1)
		begin
			d.two_byte = 1'b1;
			unique case (op[7:4])
				NIB_CALL5, NIB_CALL9: d.cyc = CYC10;
				NIB_JUMP_ACC: d.cyc = CYC7;
				NIB_TABLE: d.cyc = CYC14;
				default: d.cyc = CYC5;
			endcase
		end
		else
		begin
			unique case (op)
				OP_HALT: d.cyc = CYC7;
				OP_MOVX_IMM: d = '{1'b1, AM_IMM, CYC4};
				OP_MOVX_DIR: d = '{1'b1, AM_DIR, CYC5};
				OP_INC_DIR, OP_DEC_DIR, OP_OR_DIR, OP_AND_DIR, OP_XOR_DIR: d = '{1'b1, AM_DIR, CYC7};
				OP_INC_IDX, OP_DEC_IDX, OP_OR_IDX, OP_AND_IDX, OP_XOR_IDX: d = '{1'b1, AM_IDX, CYC8};
				OP_PORT_READ, OP_PORT_WRITE: d = '{1'b1, AM_NONE, CYC5};
				OP_PORT_WRITE_IDX: d = '{1'b1, AM_NONE, CYC6};
				OP_STORE_DIR: d = '{1'b1, AM_DIR, CYC5};
				OP_STORE_IDX: d = '{1'b1, AM_IDX, CYC6};
				OP_PUSH_A, OP_PUSH_X, OP_SWAP_AX, OP_SWAP_ADSTK: d.cyc = CYC5;
				OP_RETURN, OP_RETURN_INT: d.cyc = CYC8;
				default: d.cyc = CYC4;
			endcase
		end
		return d;
	endfunction

	// returns {carry, result}; subtract forms report borrow in the carry
	function automatic logic [8:0] alu(input logic [3:0] g, input logic [7:0] a,
		input logic [7:0] b, input logic c);
		logic [8:0] r;
		r = {c, b};
		unique case (g)
			ALU_ADD: r = {1'b0, a} + {1'b0, b};
			ALU_ADD_CARRY: r = {1'b0, a} + {1'b0, b} + {8'h00, c};
			ALU_SUB, ALU_CMP: r = {1'b0, a} - {1'b0, b};
			ALU_SUB_BORROW: r = {1'b0, a} - {1'b0, b} - {8'h00, c};
			ALU_OR: r = {c, a | b};
			ALU_AND: r = {c, a & b};
			ALU_XOR: r = {c, a ^ b};
			default: r = {c, b};
		endcase
		return r;
	endfunction

	wire umic_dec_t dec_fetch = decode(prog_rdata);
	wire umic_dec_t dec_op = decode(op_ff);
	wire [7:0] alu_idx = op_ff - OP_ALU_FIRST;
	wire [3:0] alu_grp = 4'(alu_idx / ALU_MODES);
	wire [7:0] eff_addr = (dec_op.amode == AM_IDX) ? opd_ff + x_ff : opd_ff;
	wire [7:0] mem_rd = mem_ff[eff_addr];
	wire [7:0] alu_b = (dec_op.amode == AM_IMM) ? opd_ff : mem_rd;
	wire [8:0] alu_res = alu(alu_grp, a_ff, alu_b, c_ff);
	wire [3:0] rmw_grp = ALU_OR + 4'((op_ff - OP_OR_DIR) >> 1);
	wire [8:0] rmw_res = alu(rmw_grp, mem_rd, a_ff, c_ff);
	wire [11:0] br_low = {op_ff[3:0], opd_ff};
	wire [13:0] table_addr = {2'h0, br_low} + {6'h00, a_ff};
	wire [7:0] pstk_m1 = program_stack_pointer_ff - 8'h01;
	wire [7:0] pstk_m2 = program_stack_pointer_ff - 8'h02;
	wire [7:0] pstk_p1 = program_stack_pointer_ff + 8'h01;
	wire [7:0] dstk_m1 = data_stack_ptr_ff - 8'h01;
	wire [7:0] dstk_rd = mem_ff[data_stack_ptr_ff];
	wire [7:0] stk_lo = mem_ff[pstk_m2];
	wire [7:0] stk_hi = mem_ff[pstk_m1];
	wire take_irq = (state_ff == ST_FETCH) && irq_req && ie_ff;
	wire [13:0] pc_seq = {pc_ff[13:8], pc_ff[7:0] + 8'h01};
	wire [7:0] push_hi = {c_ff, z_ff, pc_ff[13:8]};
	wire [8:0] inc_a = {1'b0, a_ff} + 9'h001;
	wire [8:0] dec_a = {1'b0, a_ff} - 9'h001;
	wire [8:0] inc_x = {1'b0, x_ff} + 9'h001;
	wire [8:0] dec_x = {1'b0, x_ff} - 9'h001;
	wire [8:0] inc_m = {1'b0, mem_rd} + 9'h001;
	wire [8:0] dec_m = {1'b0, mem_rd} - 9'h001;

	assign prog_addr = (state_ff == ST_TABLE) ? table_addr : pc_ff;
	assign io_req = io_ff;
	assign irq_ack = ack_ff;
	assign irq_enabled = ie_ff;
	assign halted = (state_ff == ST_HALT);
	assign test_area_hit = hit_ff;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_pc = pc_ff;
		nxt_a = a_ff;
		nxt_x = x_ff;
		nxt_op = op_ff;
		nxt_opd = opd_ff;
		nxt_program_stack_pointer = program_stack_pointer_ff;
		nxt_data_stack_ptr = data_stack_ptr_ff;
		nxt_c = c_ff;
		nxt_z = z_ff;
		nxt_ie = ie_ff;
		nxt_cnt = cnt_ff + 4'h1;
		nxt_cyc = cyc_ff;
		nxt_ack = 1'b0;
		nxt_io = '{addr: io_ff.addr, wdata: io_ff.wdata, wr: 1'b0, rd: 1'b0};
		// fetches into the reserved test area are flagged, never blocked
		nxt_hit = hit_ff | (((state_ff == ST_FETCH) || (state_ff == ST_OPND))
			&& (pc_ff >= TEST_AREA_BASE));
		we0 = 1'b0;
		we1 = 1'b0;
		wa0 = program_stack_pointer_ff;
		wa1 = pstk_p1;
		wd0 = pc_ff[7:0];
		wd1 = push_hi;
		unique case (state_ff)
			ST_FETCH:
			begin
				nxt_cnt = 4'h2;
				if (take_irq)
				begin
					// pc already points at the next instruction, so it is pushed as is
					we0 = 1'b1;
					we1 = 1'b1;
					nxt_program_stack_pointer = program_stack_pointer_ff + 8'h02;
					nxt_ie = 1'b0;
					nxt_pc = {9'h000, irq_vector, 1'b0};
					nxt_cyc = CYC_INTACK;
					nxt_ack = 1'b1;
					nxt_state = ST_WAIT;
				end
				else
				begin
					nxt_op = prog_rdata;
					nxt_pc = pc_seq;
					nxt_cyc = dec_fetch.cyc;
					nxt_state = dec_fetch.two_byte ? ST_OPND : ST_EXEC;
				end
			end
			ST_OPND:
			begin
				nxt_opd = prog_rdata;
				nxt_pc = pc_seq;
				nxt_state = ST_EXEC;
			end
			ST_EXEC:
			begin
				nxt_state = ST_WAIT;
				if (op_ff >= OP_ALU_FIRST && op_ff <= OP_ALU_LAST)
				begin
					if (alu_grp != ALU_MOV)
					begin
						nxt_c = alu_res[8];
						nxt_z = (alu_res[7:0] == 8'h00);
					end
					if (alu_grp != ALU_CMP)
						nxt_a = alu_res[7:0];
				end
				else if (op_ff[7:4] == NIB_CALL5 || op_ff[7:4] == NIB_CALL9)
				begin
					we0 = 1'b1;
					we1 = 1'b1;
					nxt_program_stack_pointer = program_stack_pointer_ff + 8'h02;
					nxt_pc = {(op_ff[7:4] == NIB_CALL5) ? CALL5_HI : CALL9_HI, br_low};
				end
				else if (op_ff[7] == 1'b1)
				begin
					unique case (op_ff[7:4])
						NIB_JUMP: nxt_pc = {pc_ff[13:12], br_low};
						NIB_JUMP_IF_ZERO: nxt_pc = z_ff ? {pc_ff[13:12], br_low} : pc_ff;
						NIB_JUMP_IF_NONZERO: nxt_pc = !z_ff ? {pc_ff[13:12], br_low} : pc_ff;
						NIB_JUMP_IF_CARRY: nxt_pc = c_ff ? {pc_ff[13:12], br_low} : pc_ff;
						NIB_JUMP_IF_NO_CARRY: nxt_pc = !c_ff ? {pc_ff[13:12], br_low} : pc_ff;
						NIB_JUMP_ACC: nxt_pc = {pc_ff[13:12], br_low} + {6'h00, a_ff};
						default: nxt_state = ST_TABLE;
					endcase
				end
				else
				begin
					unique case (op_ff)
						OP_HALT: nxt_state = ST_HALT;
						OP_MOVX_IMM: nxt_x = opd_ff;
						OP_MOVX_DIR: nxt_x = mem_rd;
						OP_PAGE_ADVANCE: nxt_pc = {pc_ff[13:8] + 6'h01, pc_ff[7:0]};
						OP_INC_A: {nxt_c, nxt_a} = inc_a;
						OP_DEC_A: {nxt_c, nxt_a} = dec_a;
						OP_INC_X: {nxt_c, nxt_x} = inc_x;
						OP_DEC_X: {nxt_c, nxt_x} = dec_x;
						OP_INC_DIR, OP_INC_IDX:
						begin
							we0 = 1'b1;
							wa0 = eff_addr;
							{nxt_c, wd0} = inc_m;
						end
						OP_DEC_DIR, OP_DEC_IDX:
						begin
							we0 = 1'b1;
							wa0 = eff_addr;
							{nxt_c, wd0} = dec_m;
						end
						OP_PORT_READ: nxt_io = '{opd_ff, io_ff.wdata, 1'b0, 1'b1};
						OP_PORT_WRITE: nxt_io = '{opd_ff, a_ff, 1'b1, 1'b0};
						OP_PORT_WRITE_IDX: nxt_io = '{opd_ff + x_ff, a_ff, 1'b1, 1'b0};
						OP_POP_A, OP_POP_X:
						begin
							if (op_ff == OP_POP_A)
								nxt_a = dstk_rd;
							else
								nxt_x = dstk_rd;
							nxt_data_stack_ptr = data_stack_ptr_ff + 8'h01;
						end
						OP_PUSH_A, OP_PUSH_X:
						begin
							// pre-decrement: from reset the first push lands at ff
							nxt_data_stack_ptr = dstk_m1;
							we0 = 1'b1;
							wa0 = dstk_m1;
							wd0 = (op_ff == OP_PUSH_A) ? a_ff : x_ff;
						end
						OP_SWAP_AX:
						begin
							nxt_a = x_ff;
							nxt_x = a_ff;
						end
						OP_SWAP_ADSTK:
						begin
							nxt_a = data_stack_ptr_ff;
							nxt_data_stack_ptr = a_ff;
						end
						OP_STORE_DIR, OP_STORE_IDX:
						begin
							we0 = 1'b1;
							wa0 = eff_addr;
							wd0 = a_ff;
						end
						OP_OR_DIR, OP_OR_IDX, OP_AND_DIR, OP_AND_IDX, OP_XOR_DIR, OP_XOR_IDX:
						begin
							we0 = 1'b1;
							wa0 = eff_addr;
							wd0 = rmw_res[7:0];
							nxt_z = (rmw_res[7:0] == 8'h00);
						end
						OP_COMPLEMENT:
						begin
							nxt_a = ~a_ff;
							nxt_z = (a_ff == 8'hff);
						end
						OP_SHIFT_LEFT: {nxt_c, nxt_a} = {a_ff, 1'b0};
						OP_SHIFT_RIGHT: {nxt_a, nxt_c} = {a_ff[7], a_ff};
						OP_ROT_LEFT: {nxt_c, nxt_a} = {a_ff, c_ff};
						OP_ROT_RIGHT: {nxt_a, nxt_c} = {c_ff, a_ff};
						OP_RETURN:
						begin
							nxt_pc = {stk_hi[5:0], stk_lo};
							nxt_program_stack_pointer = pstk_m2;
						end
						OP_RETURN_INT:
						begin
							// both bytes popped in one step; enable is set in that same step as the restore
							nxt_pc = {stk_hi[5:0], stk_lo};
							nxt_c = stk_hi[STK_C_BIT];
							nxt_z = stk_hi[STK_Z_BIT];
							nxt_program_stack_pointer = pstk_m2;
							nxt_ie = 1'b1;
						end
						OP_MOV_AX: nxt_a = x_ff;
						OP_MOV_XA: nxt_x = a_ff;
						OP_LOAD_PSTK: nxt_program_stack_pointer = a_ff;
						OP_INT_DISABLE: nxt_ie = 1'b0;
						OP_INT_ENABLE: nxt_ie = 1'b1;
						default: nxt_state = ST_WAIT;
					endcase
				end
				if (nxt_state == ST_WAIT && cnt_ff == cyc_ff)
					nxt_state = ST_FETCH;
			end
			ST_TABLE:
			begin
				nxt_a = prog_rdata;
				nxt_state = ST_WAIT;
			end
			ST_WAIT:
			begin
				if (io_ff.rd)
					nxt_a = io_rdata;
				if (cnt_ff == cyc_ff)
					nxt_state = ST_FETCH;
			end
			ST_HALT: nxt_cnt = cnt_ff;
			default: nxt_state = ST_FETCH;
		endcase
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_ff <= ST_FETCH;
			pc_ff <= PC_RESET;
			program_stack_pointer_ff <= PSTK_RESET;
			data_stack_ptr_ff <= DSTK_RESET;
			{a_ff, x_ff, op_ff, opd_ff} <= '0;
			{c_ff, z_ff, ie_ff, ack_ff, hit_ff} <= '0;
			cnt_ff <= 4'h1;
			cyc_ff <= CYC4;
			io_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			pc_ff <= nxt_pc;
			program_stack_pointer_ff <= nxt_program_stack_pointer;
			data_stack_ptr_ff <= nxt_data_stack_ptr;
			{a_ff, x_ff, op_ff, opd_ff} <= {nxt_a, nxt_x, nxt_op, nxt_opd};
			{c_ff, z_ff, ie_ff, ack_ff, hit_ff} <= {nxt_c, nxt_z, nxt_ie, nxt_ack, nxt_hit};
			cnt_ff <= nxt_cnt;
			cyc_ff <= nxt_cyc;
			io_ff <= nxt_io;
		end
	end

	// stack bytes stay readable as plain ram; the pc has no other read path
	for (genvar i = 0; i < RAM_DEPTH; i++)
	begin : g_ram
		always_ff @(posedge clk)
		begin
			if (we1 && wa1 == 8'(i))
				mem_ff[i] <= wd1;
			else if (we0 && wa0 == 8'(i))
				mem_ff[i] <= wd0;
		end
	end

	property p_seq_low_only;
		@(posedge clk) disable iff (!resetn)
		(state_ff == ST_FETCH && !take_irq) |=>
		pc_ff[13:8] == $past(pc_ff[13:8]) && pc_ff[7:0] == $past(pc_ff[7:0]) + 8'h01;
	endproperty
	a_seq_low_only: assert property (p_seq_low_only) else $error("fetch changed upper pc bits");

	property p_page_advance;
		@(posedge clk) disable iff (!resetn)
		(state_ff == ST_EXEC && op_ff == OP_PAGE_ADVANCE) |=> pc_ff[13:8] == $past(pc_ff[13:8]) + 6'h01;
	endproperty
	a_page_advance: assert property (p_page_advance) else $error("page advance failed");

	property p_add_imm_timing;
		@(posedge clk) disable iff (!resetn)
		(state_ff == ST_FETCH && !take_irq && prog_rdata == OP_ALU_FIRST) |=>
		state_ff == ST_OPND ##1 state_ff == ST_EXEC ##1 state_ff == ST_WAIT ##1 state_ff == ST_FETCH;
	endproperty
	a_add_imm_timing: assert property (p_add_imm_timing) else $error("add immediate not 4 cycles");

	property p_jump_timing;
		@(posedge clk) disable iff (!resetn)
		(state_ff == ST_FETCH && !take_irq && prog_rdata[7:4] == NIB_JUMP) |=>
		(state_ff != ST_FETCH) [*4] ##1 state_ff == ST_FETCH;
	endproperty
	a_jump_timing: assert property (p_jump_timing) else $error("jump not 5 cycles");

	property p_intack_push;
		@(posedge clk) disable iff (!resetn)
		take_irq |=> !ie_ff && program_stack_pointer_ff == $past(program_stack_pointer_ff) + 8'h02
		&& mem_ff[pstk_m2] == $past(pc_ff[7:0]);
	endproperty
	a_intack_push: assert property (p_intack_push) else $error("interrupt push wrong");

	property p_return_int;
		@(posedge clk) disable iff (!resetn)
		(state_ff == ST_EXEC && op_ff == OP_RETURN_INT) |=>
		ie_ff && c_ff == $past(stk_hi[STK_C_BIT])
		&& program_stack_pointer_ff == $past(program_stack_pointer_ff) - 8'h02;
	endproperty
	a_return_int: assert property (p_return_int) else $error("interrupt return wrong");

	property p_return_keeps_flags;
		@(posedge clk) disable iff (!resetn)
		(state_ff == ST_EXEC && op_ff == OP_RETURN) |=>
		c_ff == $past(c_ff) && z_ff == $past(z_ff) && pc_ff == $past({stk_hi[5:0], stk_lo});
	endproperty
	a_return_keeps_flags: assert property (p_return_keeps_flags) else $error("return touched flags");

	property p_push;
		@(posedge clk) disable iff (!resetn)
		(state_ff == ST_EXEC && op_ff == OP_PUSH_A) |=>
		data_stack_ptr_ff == $past(data_stack_ptr_ff) - 8'h01 && dstk_rd == $past(a_ff);
	endproperty
	a_push: assert property (p_push) else $error("push order wrong");

	property p_pop;
		@(posedge clk) disable iff (!resetn)
		(state_ff == ST_EXEC && op_ff == OP_POP_A) |=>
		data_stack_ptr_ff == $past(data_stack_ptr_ff) + 8'h01 && a_ff == $past(dstk_rd);
	endproperty
	a_pop: assert property (p_pop) else $error("pop order wrong");

	property p_swap_dstk;
		@(posedge clk) disable iff (!resetn)
		(state_ff == ST_EXEC && op_ff == OP_SWAP_ADSTK) |=>
		data_stack_ptr_ff == $past(a_ff) && a_ff == $past(data_stack_ptr_ff);
	endproperty
	a_swap_dstk: assert property (p_swap_dstk) else $error("swap with data stack failed");

	property p_load_pstk;
		@(posedge clk) disable iff (!resetn)
		(state_ff == ST_EXEC && op_ff == OP_LOAD_PSTK) |=> program_stack_pointer_ff == $past(a_ff);
	endproperty
	a_load_pstk: assert property (p_load_pstk) else $error("stack pointer load failed");
endmodule

//--- umic_core_tb.sv
// self-checking bench for the instruction core: runs three small programs, watches the port bus
`timescale 1ns/1ns
module umic_core_tb;
	import umic_pkg::*;
	logic clk;
	logic resetn;
	logic [13:0] prog_addr;
	logic [7:0] prog_rdata;
	umic_io_t io_req;
	logic [7:0] io_rdata;
	logic irq_req;
	logic [3:0] irq_vector;
	logic irq_ack;
	logic irq_enabled;
	logic halted;
	logic test_area_hit;
	logic [7:0] rom [0:255];
	int failures;
	int compares;
	int cycles;
	logic [7:0] wr_addr [$];
	logic [7:0] wr_data [$];
	int wr_cyc [$];
	logic [7:0] rd_addr;

	// program memory answers in the same cycle; unused space reads as halt
	assign prog_rdata = (prog_addr[13:8] == 6'h00) ? rom[prog_addr[7:0]] : 8'h00;

	umic_core u_dut (
		.clk(clk),
		.resetn(resetn),
		.prog_addr(prog_addr),
		.prog_rdata(prog_rdata),
		.io_req(io_req),
		.io_rdata(io_rdata),
		.irq_req(irq_req),
		.irq_vector(irq_vector),
		.irq_ack(irq_ack),
		.irq_enabled(irq_enabled),
		.halted(halted),
		.test_area_hit(test_area_hit)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// log every port write with its cycle so instruction lengths can be judged
	always @(posedge clk)
	begin
		cycles++;
		if (io_req.wr === 1'b1)
		begin
			wr_addr.push_back(io_req.addr);
			wr_data.push_back(io_req.wdata);
			wr_cyc.push_back(cycles);
		end
		if (io_req.rd === 1'b1)
			rd_addr = io_req.addr;
		if (cycles == 3000)
		begin
			failures++;
			summarize();
		end
	end

	task automatic test_reset();
		check(prog_addr, 14'h0000);
		check({halted, irq_enabled, test_area_hit}, 3'h0);
		@(posedge clk);
		#1 resetn = 1'b1;
		#1 check(prog_addr, 14'h0000);
	endtask

	task automatic test_program();
		int n;
		n = 0;
		while (halted !== 1'b1 && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		#1 check(halted, 1'b1);
		check(16'(wr_addr.size()), 16'd6);
		if (wr_addr.size() == 6)
		begin
			check({wr_addr[0], wr_data[0]}, 16'h125a);
			check({wr_addr[1], wr_data[1]}, 16'h1377);
			check({wr_addr[2], wr_data[2]}, 16'h1477);
			check({wr_addr[3], wr_data[3]}, 16'h15ff);
			check({wr_addr[4], wr_data[4]}, 16'h16c3);
			check({wr_addr[5], wr_data[5]}, 16'h13c3);
			// gaps between writes are the summed lengths of the first write and the instructions between them
			check(16'(wr_cyc[1] - wr_cyc[0]), 16'd9);
			check(16'(wr_cyc[2] - wr_cyc[1]), 16'd19);
			check(16'(wr_cyc[3] - wr_cyc[2]), 16'd10);
			check(16'(wr_cyc[4] - wr_cyc[3]), 16'd10);
		end
		check(rd_addr, 8'h20);
		check(test_area_hit, 1'b0);
	endtask

	// writes n bytes into program memory, first byte in the highest used bits of b
	task automatic put(input logic [7:0] at, input int n, input logic [63:0] b);
		for (int i = 0; i < n; i++)
			rom[at + 8'(i)] = b[8 * (n - 1 - i) +: 8];
	endtask

	// mid-run reset: one edge low is enough, the core's reset is asynchronous
	task automatic reboot();
		wr_addr.delete();
		wr_data.delete();
		wr_cyc.delete();
		resetn = 1'b0;
		@(posedge clk);
		#1 resetn = 1'b1;
	endtask

	task automatic run_to_halt();
		int n;
		n = 0;
		while (halted !== 1'b1 && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		#1 check(halted, 1'b1);
	endtask

	// stack at 40, flags c=0 z=1, enable; the waiting request is taken at 06 and the
	// handler reports both stacked bytes, clears z and returns; a zero-jump needs z back,
	// a call whose body sets carry needs a carry-jump after return, then push/pop and
	// a jump to ff where the page advance must land at 100 instead of wrapping to 000
	task automatic test_interrupt();
		int n;
		n = 0;
		for (int i = 0; i < 256; i++)
			rom[i] = 8'h00;
		put(8'h00, 8, 64'h1940_6016_4072_a030);
		put(8'h08, 2, 64'h2a3f);
		put(8'h10, 8, 64'h1a40_2a20_1a41_2a21);
		put(8'h18, 3, 64'h0101_73);
		put(8'h30, 6, 64'h9050_c038_2a3f);
		put(8'h38, 8, 64'h2a24_2d19_002b_2a25);
		put(8'h40, 2, 64'h80ff);
		put(8'h50, 7, 64'h1a_402a_2307_413f);
		put(8'hff, 1, 64'h1f);
		irq_vector = 4'h8;
		irq_req = 1'b1;
		reboot();
		while (irq_ack !== 1'b1 && n < 100)
		begin
			@(posedge clk);
			n++;
		end
		#1 irq_req = 1'b0;
		check(16'(n), 16'h0013);
		check(irq_enabled, 1'b0);
		run_to_halt();
		check(16'(wr_addr.size()), 16'h0005);
		if (wr_addr.size() == 5)
		begin
			check({wr_addr[0], wr_data[0]}, 16'h2006);
			check({wr_addr[1], wr_data[1]}, 16'h2140);
			check({wr_addr[2], wr_data[2]}, 16'h2332);
			check({wr_addr[3], wr_data[3]}, 16'h24f1);
			check({wr_addr[4], wr_data[4]}, 16'h25f1);
		end
		check(prog_addr, 14'h0101);
		check(irq_enabled, 1'b1);
	endtask

	// a call from the upper-half form lands in the reserved test area
	task automatic test_area();
		for (int i = 0; i < 256; i++)
			rom[i] = 8'h00;
		put(8'h00, 2, 64'h5fe0);
		reboot();
		run_to_halt();
		check(prog_addr, 14'h1fe1);
		check(test_area_hit, 1'b1);
	endtask

	initial
	begin
		failures = 0;
		compares = 0;
		cycles = 0;
		resetn = 1'b0;
		irq_req = 1'b0;
		irq_vector = 4'h0;
		io_rdata = 8'hc3;
		for (int i = 0; i < 256; i++)
			rom[i] = 8'h00;
		// mov a,5a; port write 12; mov a,77; port write 13; push a; mov a,0; mov a,[ff];
		// port write 14; swap a,dsp; port write 15; port read 20; port write 16; mov x,3;
		// indexed port write 10; halt
		{rom[0], rom[1], rom[2], rom[3], rom[4], rom[5], rom[6], rom[7]} = 64'h195a_2a12_1977_2a13;
		{rom[8], rom[9], rom[10], rom[11], rom[12], rom[13], rom[14]} = 56'h2d_1900_1aff_2a14;
		{rom[15], rom[16], rom[17], rom[18], rom[19]} = 40'h30_2a15_2920;
		{rom[20], rom[21], rom[22], rom[23], rom[24], rom[25]} = 48'h2a16_1c03_3910;
		// the reset task waits one more edge, so reset spans 8 cycles in all
		repeat (7) @(posedge clk);
		#1 test_reset();
		test_program();
		test_interrupt();
		test_area();
		summarize();
	end
endmodule
